// ---- rtl/esrf_pkg.sv ----
// Constants for the extended status and relay output framer.
// Assumes a byte-wide serial API transmitter downstream of the framer.
package esrf_pkg;
  localparam logic [7:0] START_BYTE       = 8'h7e;
  localparam logic [7:0] TYPE_EXT_STATUS  = 8'h98;
  localparam logic [7:0] TYPE_UNLOCK_RESP = 8'hac;
  localparam logic [7:0] TYPE_RELAY_OUT   = 8'had;
  localparam logic [7:0] TYPE_TX_STATUS   = 8'h89;
  localparam logic [7:0] SC_ESTABLISHED   = 8'h3b;
  localparam logic [7:0] SC_ENDED         = 8'h3c;
  localparam logic [7:0] SC_AUTH_FAIL     = 8'h3d;
  localparam logic [7:0] REASON_PEER      = 8'h00;
  localparam logic [7:0] REASON_TIMEOUT   = 8'h01;
  localparam logic [7:0] REASON_BAD_CNT   = 8'h02;
  localparam logic [7:0] REASON_CNT_OVF   = 8'h03;
  localparam logic [7:0] REASON_NO_MEM    = 8'h04;
  localparam logic [7:0] ERR_BAD_IFACE    = 8'h7c;
  localparam logic [7:0] ERR_IFACE_BUSY   = 8'h7d;
  localparam logic [7:0] IFACE_SERIAL     = 8'h00;
  localparam logic [7:0] IFACE_BLE        = 8'h01;
  localparam logic [7:0] IFACE_SCRIPT     = 8'h02;
  localparam logic [7:0] CSUM_BASE        = 8'hff;
  // Transmit status body after the frame id: retries, delivery status
  localparam logic [7:0] TXS_RETRY        = 8'h00;
  // Fixed body lengths (type byte through end of payload)
  localparam logic [15:0] LEN_ESTABLISHED = 16'h000d;
  localparam logic [15:0] LEN_ENDED       = 16'h000b;
  localparam logic [15:0] LEN_TX_STATUS   = 16'h0004;
  // Maximum payload bytes held for relay and unlock frames
  localparam int unsigned MAX_DATA        = 64;
  // Request kinds
  typedef enum logic [2:0] {
    ESRF_REQ_ESTAB  = 3'h0,
    ESRF_REQ_ENDED  = 3'h1,
    ESRF_REQ_AUTHF  = 3'h2,
    ESRF_REQ_UNLOCK = 3'h3,
    ESRF_REQ_RELAY  = 3'h4
  } esrf_req_e;
endpackage : esrf_pkg

// ---- rtl/esrf_skid.sv ----
// Two-entry byte buffer with valid/ready on both sides.
// Assumes source and sink share core_clk_in.
`timescale 1ns/1ns
module esrf_skid #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  // Fill side
  input  wire logic [W-1:0] s_data_in,
  input  wire logic         s_valid_in,
  output logic              s_ready_out,
  // Drain side
  output logic [W-1:0]      m_data_out,
  output logic              m_valid_out,
  input  wire logic         m_ready_in
);
  logic [W-1:0] mem [2];   // Storage for two words
  logic         wr_ptr;    // Next slot to write
  logic         rd_ptr;    // Next slot to read
  logic [1:0]   count;     // Words held

  logic push;
  logic pop;
  assign s_ready_out = (count != 2'h2);
  assign m_valid_out = (count != 2'h0);
  assign push        = s_valid_in && s_ready_out;
  assign pop         = m_valid_out && m_ready_in;
  // Head word comes straight from a storage flop
  assign m_data_out  = mem[rd_ptr];

  // Storage write; no reset needed on data
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= s_data_in;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : esrf_skid

// ---- rtl/esrf_framer.sv ----
// Framer that builds extended status, unlock response, relay output
// and transmit status frames as a byte stream toward the API port.
// One frame is in flight at a time; the output buffer absorbs short
// stalls, and longer ones simply hold the sequencer where it stands.
// Escaping of reserved bytes is left to the port logic downstream.
// Assumes the requester holds req_valid_in until req_ready_out, and
// streams payload bytes on demand while the frame is in progress.
`timescale 1ns/1ns
module esrf_framer
  import esrf_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Configuration
  input  wire logic        ext_session_report_in,
  // Event request
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic [2:0]  req_kind_in,
  input  wire logic [63:0] req_addr_in,
  input  wire logic [7:0]  req_byte_in,
  input  wire logic [15:0] req_timeout_in,
  input  wire logic [7:0]  req_iface_in,
  input  wire logic [7:0]  req_frame_id_in,
  input  wire logic [15:0] req_len_in,
  input  wire logic        dest_exists_in,
  input  wire logic        dest_accepts_in,
  // Payload byte stream for unlock and relay frames
  input  wire logic [7:0]  pay_data_in,
  output logic             pay_take_out,
  // Relay completion
  output logic             relay_done_out,
  // Serial frame output
  output logic [7:0]       tx_data_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in
);

  ////////////////////////////////////////////////////////////////////
  // State and latched request

  // One-hot sequence: header, fixed body, streamed payload, checksum,
  // then one quiet cycle so the next request sees a settled frame.
  // The extra cycle costs little and keeps request spacing simple.
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_HDR   = 6'b000010,
    ST_FIXED = 6'b000100,
    ST_PAY   = 6'b001000,
    ST_CSUM  = 6'b010000,
    ST_DONE  = 6'b100000
  } esrf_state_e;

  esrf_state_e state;        // Framer sequence
  // Frame bytes held from acceptance until the frame has left
  logic [7:0]  hdr [4];      // Start byte, length, type
  logic [7:0]  fix [12];     // Fixed body bytes after type
  logic [3:0]  fix_n;        // Number of fixed body bytes
  logic [15:0] pay_n;        // Number of streamed payload bytes
  logic [15:0] idx;          // Byte index within current section
  logic [7:0]  sum;          // Running sum from type byte onward
  logic        is_relay;     // Frame is a relayed data frame

  logic [7:0]  cur_byte;     // Byte offered to the buffer
  logic        cur_valid;    // Offer is valid
  logic        buf_ready;    // Buffer accepts the offer
  logic        adv;          // Byte accepted this cycle
  logic        sum_it;       // Byte counts toward the checksum

  ////////////////////////////////////////////////////////////////////
  // Request acceptance

  // A request is taken only while idle; session events are still
  // taken when reporting is off, so the requester never stalls on
  // them, but they are swallowed without a frame.
  logic       accept;        // Request taken at this edge
  logic       drop;          // Request produces no frame
  // Session frames are swallowed unless reporting is selected
  assign drop = (req_kind_in <= 3'(ESRF_REQ_AUTHF))
             && !ext_session_report_in;
  assign req_ready_out = (state == ST_IDLE);
  assign accept        = req_valid_in && req_ready_out;

  logic relay_ok;            // Destination exists and takes data
  // A relay to an interface up to IFACE_SCRIPT whose destination exists
  // and accepts data is emitted as a data frame; any other outcome
  // becomes a transmit status error
  assign relay_ok = dest_exists_in && dest_accepts_in;

  ////////////////////////////////////////////////////////////////////
  // Frame assembly on acceptance

  // Every byte of the header and fixed body is captured at the taking
  // edge, so the requester may change its fields as soon as it is
  // released. Only the payload is fetched later, one byte per take.
  // Dropped requests also load these registers; the sequencer never
  // reads them, so that is harmless and saves a qualifier.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      // Quiet contents so nothing undefined is ever offered
      fix_n    <= 4'h0;
      pay_n    <= 16'h0000;
      is_relay <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        hdr[i] <= 8'h00;
      end
      for (int i = 0; i < 12; i++) begin
        fix[i] <= 8'h00;
      end
    end else if (accept) begin
      // Defaults first; the kind branches below override them
      is_relay <= 1'b0;
      hdr[0]   <= START_BYTE;
      pay_n    <= 16'h0000;
      // Address bytes sit after the status code for all session kinds
      for (int i = 0; i < 8; i++) begin
        fix[i + 1] <= req_addr_in[63 - 8*i -: 8];
      end
      case (req_kind_in)
        // Established: code, address, options, timeout
        3'(ESRF_REQ_ESTAB): begin
          hdr[1] <= LEN_ESTABLISHED[15:8];
          hdr[2] <= LEN_ESTABLISHED[7:0];
          hdr[3] <= TYPE_EXT_STATUS;
          fix[0] <= SC_ESTABLISHED;
          fix[9] <= req_byte_in;
          fix[10] <= req_timeout_in[15:8];
          fix[11] <= req_timeout_in[7:0];
          fix_n  <= 4'd12;
        end
        // Ended and failed share one layout: code, address, one byte
        3'(ESRF_REQ_ENDED), 3'(ESRF_REQ_AUTHF): begin
          hdr[1] <= LEN_ENDED[15:8];
          hdr[2] <= LEN_ENDED[7:0];
          hdr[3] <= TYPE_EXT_STATUS;
          fix[0] <= (req_kind_in == 3'(ESRF_REQ_ENDED))
                    ? SC_ENDED : SC_AUTH_FAIL;
          // Reason (0x00..0x04) or error byte passed as given
          fix[9] <= req_byte_in;
          fix_n  <= 4'd10;
        end
        // Unlock answer: type byte then the streamed body
        3'(ESRF_REQ_UNLOCK): begin
          // Body mirrors the request layout, streamed from the source
          hdr[1] <= 8'((req_len_in + 16'd1) >> 8);
          hdr[2] <= 8'(req_len_in + 16'd1);
          hdr[3] <= TYPE_UNLOCK_RESP;
          fix_n  <= 4'd0;
          pay_n  <= req_len_in;
        end
        // Relay: data frame on success, status frame on error
        default: begin
          if (!dest_exists_in
              || req_iface_in > IFACE_SCRIPT) begin
            // Unknown destination: transmit status with error
            hdr[1] <= LEN_TX_STATUS[15:8];
            hdr[2] <= LEN_TX_STATUS[7:0];
            hdr[3] <= TYPE_TX_STATUS;
            fix[0] <= req_frame_id_in;
            fix[1] <= TXS_RETRY;
            fix[2] <= ERR_BAD_IFACE;
            fix_n  <= 4'd3;
          end else if (!relay_ok) begin
            // Valid destination that cannot take data right now
            hdr[1] <= LEN_TX_STATUS[15:8];
            hdr[2] <= LEN_TX_STATUS[7:0];
            hdr[3] <= TYPE_TX_STATUS;
            fix[0] <= req_frame_id_in;
            fix[1] <= TXS_RETRY;
            fix[2] <= ERR_IFACE_BUSY;
            fix_n  <= 4'd3;
          end else begin
            // Relayed data out of the serial port; no status frame
            // follows a clean relay, the data frame is all there is
            hdr[1] <= 8'((req_len_in + 16'd2) >> 8);
            hdr[2] <= 8'(req_len_in + 16'd2);
            hdr[3] <= TYPE_RELAY_OUT;
            fix[0] <= req_iface_in;
            fix_n  <= 4'd1;
            pay_n  <= req_len_in;
            is_relay <= 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  // A byte moves only when the buffer takes it, so a stalled host
  // freezes the sequencer with the current byte still on offer.
  assign adv = cur_valid && buf_ready;

  // Walks the sections of the frame; idx counts bytes within the
  // section and returns to zero whenever a section is left.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      idx   <= 16'h0000;
    end else begin
      case (state)
        // Dropped requests leave the framer idle
        ST_IDLE: begin
          idx <= 16'h0000;
          if (accept && !drop) begin
            state <= ST_HDR;
          end
        end
        // Start byte, two length bytes, type byte
        ST_HDR: begin
          if (adv) begin
            if (idx == 16'd3) begin
              idx   <= 16'h0000;
              state <= (fix_n != 4'h0) ? ST_FIXED
                     : (pay_n != 16'h0) ? ST_PAY : ST_CSUM;
            end else begin
              idx <= idx + 16'd1;
            end
          end
        end
        // Fixed body captured at acceptance
        ST_FIXED: begin
          if (adv) begin
            if (idx == {12'h000, fix_n} - 16'd1) begin
              idx   <= 16'h0000;
              state <= (pay_n != 16'h0) ? ST_PAY : ST_CSUM;
            end else begin
              idx <= idx + 16'd1;
            end
          end
        end
        // A payload length of zero never enters here
        ST_PAY: begin
          if (adv) begin
            if (idx == pay_n - 16'd1) begin
              idx   <= 16'h0000;
              state <= ST_CSUM;
            end else begin
              idx <= idx + 16'd1;
            end
          end
        end
        // Checksum byte closes the frame
        ST_CSUM: begin
          if (adv) begin
            state <= ST_DONE;
          end
        end
        // One quiet cycle before the next request
        ST_DONE: begin
          state <= ST_IDLE;
        end
        // Any code outside the one-hot set falls back to idle
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Byte selection and checksum

  // Picks the byte on offer for the current section. The payload byte
  // passes straight through, so the source must present it whenever
  // the sequencer sits in the payload section.
  always_comb begin
    cur_byte  = 8'h00;
    cur_valid = 1'b0;
    sum_it    = 1'b0;
    case (state)
      // Only the type byte of the header joins the sum
      ST_HDR: begin
        cur_byte  = hdr[idx[1:0]];
        cur_valid = 1'b1;
        sum_it    = (idx == 16'd3);
      end
      // Index never passes the fixed count, at most twelve
      ST_FIXED: begin
        cur_byte  = fix[idx[3:0]];
        cur_valid = 1'b1;
        sum_it    = 1'b1;
      end
      // Source byte goes out unchanged
      ST_PAY: begin
        cur_byte  = pay_data_in;
        cur_valid = 1'b1;
        sum_it    = 1'b1;
      end
      // Sum is complete once the last body byte has moved
      ST_CSUM: begin
        cur_byte  = CSUM_BASE - sum;
        cur_valid = 1'b1;
      end
      // Idle and quiet cycles offer nothing
      default: begin
        cur_valid = 1'b0;
      end
    endcase
  end

  // Low eight bits of the sum from the type byte to payload end.
  // Cleared while idle so a dropped request cannot leave residue.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sum <= 8'h00;
    end else if (state == ST_IDLE) begin
      sum <= 8'h00;
    end else if (adv && sum_it) begin
      sum <= sum + cur_byte;
    end
  end

  // Payload byte is consumed exactly when it enters the buffer
  assign pay_take_out = (state == ST_PAY) && adv;

  // Pulse when a relayed data frame has been fully offered, or when
  // a swallowed session request is taken, so the requester can tell
  // that the work is finished. Error frames give no pulse.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      relay_done_out <= 1'b0;
    end else begin
      relay_done_out <= (state == ST_DONE && is_relay)
                     || (accept && drop);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output buffer so a stalled receiver loses no byte

  // Two entries keep full rate while the host is ready and hold the
  // head byte steady while it is not.
  esrf_skid #(
    .W (8)
  ) u_skid (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .s_data_in   (cur_byte),
    .s_valid_in  (cur_valid),
    .s_ready_out (buf_ready),
    .m_data_out  (tx_data_out),
    .m_valid_out (tx_valid_out),
    .m_ready_in  (tx_ready_in)
  );

endmodule : esrf_framer

// ---- verification/esrf_framer_checker.sv ----
// Port checker for the framer, bound from the testbench top.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/1ns
module esrf_framer_checker
  import esrf_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  // Request side
  input wire logic       ext_session_report_in,
  input wire logic       req_valid_in,
  input wire logic       req_ready_out,
  input wire logic [2:0] req_kind_in,
  input wire logic       pay_take_out,
  input wire logic       relay_done_out,
  // Frame byte side
  input wire logic [7:0] tx_data_out,
  input wire logic       tx_valid_out,
  input wire logic       tx_ready_in
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic take;  // Request taken at this edge
  logic sess;  // Kind is a session status event
  logic drop;  // Session event while reporting is off
  assign take = req_valid_in && req_ready_out;
  assign sess = req_kind_in <= 3'h2;
  assign drop = sess && !ext_session_report_in;
  ////////////////////////////////////////////////////////////////////////
  // Reset holds tx_valid_out and pay_take_out low and req_ready_out high, so it is checked during reset
  a_reset_quiet: assert property (@(posedge core_clk_in) disable iff (1'b0)
    rst_in |-> !tx_valid_out && req_ready_out && !pay_take_out)
    else $error("outputs active in reset");
  // Only with an empty buffer is the next byte the new frame's start
  a_start_byte: assert property (take && !drop && !tx_valid_out |->
    ##2 tx_valid_out && tx_data_out == START_BYTE)
    else $error("frame did not open with start byte");
  a_dropped_silent: assert property (take && drop && !tx_valid_out |=>
    !tx_valid_out [*4])
    else $error("frame sent while reporting off");
  // A stalled byte must not move, or the host loses it
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out))
    else $error("byte changed during stall");
  a_busy_after: assert property (take && !drop |=> !req_ready_out)
    else $error("request accepted in mid frame");
  a_take_busy: assert property (pay_take_out |-> !req_ready_out)
    else $error("payload taken while idle");
  a_done_pulse: assert property (relay_done_out |=> !relay_done_out)
    else $error("relay done longer than a pulse");
  a_sess_no_take: assert property (take && sess |=>
    !pay_take_out [*8])
    else $error("session frame took payload");
endmodule : esrf_framer_checker

// ---- verification/esrf_host.sv ----
// Host model on the serial API side: takes frame bytes, can stall.
// Assumes it shares the framer's clock; the bench reads rx_q.
`timescale 1ns/1ns
module esrf_host (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Stall pattern select
  input  wire logic       slow_in,
  // Frame byte stream
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out = 1'b0
);
  logic [7:0] rx_q[$];    // Bytes in arrival order
  logic [1:0] ph = 2'h0;  // Stall phase
  ////////////////////////////////////////////////////////////////////////
  // Ready moves off the sampling edge; slow takes one byte in four,
  // which fills the framer's buffer and forces it to wait
  always @(negedge clk_in) begin
    ph <= ph + 2'h1;
    tx_ready_out <= !rst_in && (!slow_in || ph == 2'h3);
  end
  // Bytes kept whole and in order; checksum and fields judged later
  always @(posedge clk_in)
    if (!rst_in && tx_valid_in && tx_ready_out) rx_q.push_back(tx_data_in);
endmodule : esrf_host

// ---- verification/esrf_framer_tb.sv ----
// Testbench for the framer: one task per frame kind.
// Assumes the host model and the checker files compile before it.
`timescale 1ns/1ns
module esrf_framer_tb;
  import esrf_pkg::*;
  logic        clk = 0, rst = 0, rep = 1, rv = 0, slow = 0;
  logic [2:0]  kind = 3'h0;
  logic [63:0] addr = 64'h0123456789abcdef;  // Session peer address
  logic [7:0]  rb = 8'h00, ifc = 8'h00, fid = 8'h00, pd = 8'h00;
  logic [15:0] tmo = 16'h4650, len = 16'h0000;
  logic        dex = 1, dac = 1, done_seen = 0;
  logic        rr, take, done, tv, trdy;
  logic [7:0]  td;
  logic [7:0]  pay[8] = '{8'h52, 8'h65, 8'h6c, 8'h61, 8'h79, 8'h20, 8'h44,
                          8'h61};  // Payload source bytes
  logic [7:0]  body[$], exp_q[$];
  int          pidx = 0, error_cnt = 0, samples_checked = 0;
  always #5 clk = ~clk;
  // Present the next payload byte the cycle after one is taken
  always @(posedge clk) if (take) pidx <= pidx + 1;
  always @(posedge clk) if (done) done_seen <= 1'b1;
  always @(negedge clk) pd <= pay[pidx[2:0]];
  esrf_framer i_esrf_framer (.core_clk_in(clk), .rst_in(rst),
    .ext_session_report_in(rep), .req_valid_in(rv), .req_ready_out(rr),
    .req_kind_in(kind), .req_addr_in(addr), .req_byte_in(rb),
    .req_timeout_in(tmo), .req_iface_in(ifc), .req_frame_id_in(fid),
    .req_len_in(len), .dest_exists_in(dex), .dest_accepts_in(dac),
    .pay_data_in(pd), .pay_take_out(take), .relay_done_out(done),
    .tx_data_out(td), .tx_valid_out(tv), .tx_ready_in(trdy));
  esrf_host i_esrf_host (.clk_in(clk), .rst_in(rst), .slow_in(slow),
    .tx_data_in(td), .tx_valid_in(tv), .tx_ready_out(trdy));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s: %h not %h", $time, m, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic hang(input string m);
    error_cnt++;
    $display("CHECK FAILED t=%0t wait expired: %s", $time, m);
    stop_test();
  endtask : hang
  // Hold the request until the framer takes it, then release
  task automatic send(input logic [2:0] k);
    int n;
    n = 0;
    @(negedge clk) pidx = 0;
    @(negedge clk) kind = k;
    rv = 1;
    do @(posedge clk); while (rr !== 1'b1 && ++n < 300);
    if (n >= 300) hang("request");
    @(negedge clk) rv = 0;
  endtask : send
  task automatic push_addr();
    for (int i = 7; i >= 0; i--) body.push_back(addr[i*8 +: 8]);
  endtask : push_addr
  // Expected frame from body; compares all bytes and the byte count
  task automatic expect_frame(input logic [7:0] typ);
    logic [7:0] s;
    int n;
    s = typ;
    n = 0;
    foreach (body[i]) s += body[i];
    exp_q = {START_BYTE, 8'h00, 8'(body.size() + 1), typ};
    exp_q = {exp_q, body, CSUM_BASE - s};
    while (i_esrf_host.rx_q.size() < exp_q.size() && n++ < 3000)
      @(posedge clk);
    if (n >= 3000) hang("frame");
    repeat (8) @(negedge clk);
    check(8'(i_esrf_host.rx_q.size()), 8'(exp_q.size()), "count");
    foreach (exp_q[i]) check(i_esrf_host.rx_q[i], exp_q[i], "byte");
    i_esrf_host.rx_q.delete();
    body.delete();
  endtask : expect_frame
  ////////////////////////////////////////////////////////////////////////
  task automatic t_estab();
    rb = 8'h5a;
    send(ESRF_REQ_ESTAB);
    body = {SC_ESTABLISHED};
    push_addr();
    body = {body, rb, tmo[15:8], tmo[7:0]};
    expect_frame(TYPE_EXT_STATUS);
  endtask : t_estab
  // All reason codes, one frame at a time, with the host stalling
  task automatic t_ended();
    logic [7:0] rs[5] = '{REASON_PEER, REASON_TIMEOUT, REASON_BAD_CNT,
                          REASON_CNT_OVF, REASON_NO_MEM};
    slow = 1;
    foreach (rs[i]) begin
      rb = rs[i];
      send(ESRF_REQ_ENDED);
      body = {SC_ENDED};
      push_addr();
      body.push_back(rb);
      expect_frame(TYPE_EXT_STATUS);
    end
    slow = 0;
  endtask : t_ended
  task automatic t_authf();
    rb = 8'h03;
    send(ESRF_REQ_AUTHF);
    body = {SC_AUTH_FAIL};
    push_addr();
    body.push_back(rb);
    expect_frame(TYPE_EXT_STATUS);
  endtask : t_authf
  task automatic t_dropped();
    rep = 0;
    done_seen = 0;
    for (int k = 0; k < 3; k++) send(3'(k));
    repeat (30) @(negedge clk);
    check(8'(i_esrf_host.rx_q.size()), 8'h00, "dropped");
    check(8'(done_seen), 8'h01, "drop done");
    rep = 1;
  endtask : t_dropped
  task automatic t_unlock();
    len = 16'h0003;
    send(ESRF_REQ_UNLOCK);
    body = {pay[0], pay[1], pay[2]};
    expect_frame(TYPE_UNLOCK_RESP);
  endtask : t_unlock
  // Every source interface; success gives the data frame alone
  task automatic t_relay_ok();
    len = 16'h0005;
    for (int i = 0; i < 3; i++) begin
      ifc = 8'(i);
      slow = i[0];
      done_seen = 0;
      send(ESRF_REQ_RELAY);
      body = {ifc, pay[0], pay[1], pay[2], pay[3], pay[4]};
      expect_frame(TYPE_RELAY_OUT);
      check(8'(done_seen), 8'h01, "relay done");
    end
    slow = 0;
  endtask : t_relay_ok
  // Missing, unsupported and busy destinations
  task automatic t_relay_err();
    logic [7:0] ex[3] = '{ERR_BAD_IFACE, ERR_BAD_IFACE, ERR_IFACE_BUSY};
    for (int i = 0; i < 3; i++) begin
      dex = i != 0;
      dac = i != 2;
      ifc = i == 1 ? IFACE_SCRIPT + 8'h01 : IFACE_BLE;
      fid = 8'h27 + 8'(i);
      done_seen = 0;
      send(ESRF_REQ_RELAY);
      body = {fid, TXS_RETRY, ex[i]};
      expect_frame(TYPE_TX_STATUS);
      check(8'(done_seen), 8'h00, "error relay done");
    end
    dex = 1;
    dac = 1;
  endtask : t_relay_err
  initial begin
    // Raised after time zero so the asynchronous reset edge is seen
    #1 rst = 1;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 0;
    t_estab();
    t_ended();
    t_authf();
    t_dropped();
    t_unlock();
    t_relay_ok();
    t_relay_err();
    stop_test();
  end
endmodule : esrf_framer_tb
bind esrf_framer esrf_framer_checker i_esrf_framer_checker (.core_clk_in,
  .rst_in, .ext_session_report_in, .req_valid_in, .req_ready_out,
  .req_kind_in, .pay_take_out, .relay_done_out, .tx_data_out,
  .tx_valid_out, .tx_ready_in);
